// ===== design/mlf_pkg.sv
// Package for the monitor, converter and laser-safety fault block.
// Assumes a byte-wide register port driven by the serial interface logic.
package mlf_pkg;
	// Register offsets
	localparam logic [7:0] MLF_MON_MODE_ADDR = 8'h0A;
	localparam logic [7:0] MLF_BIAS_THR_ADDR = 8'h0B;
	localparam logic [7:0] MLF_PD_THR_ADDR = 8'h0C;
	localparam logic [7:0] MLF_CONV_CTRL_ADDR = 8'h0D;
	localparam logic [7:0] MLF_RES_HIGH_ADDR = 8'h0E;
	localparam logic [7:0] MLF_RES_LOW_ADDR = 8'h0F;
	// Field positions
	localparam int MLF_ANA_PD_FLT_BIT = 2;
	localparam int MLF_DIG_PD_BIT = 1;
	localparam int MLF_DIG_BIAS_BIT = 0;
	localparam int MLF_CONV_OFF_BIT = 7;
	localparam int MLF_OSC_OFF_BIT = 6;
	// Reset value and write masks
	localparam logic [7:0] MLF_REG_RESET = 8'h00;
	localparam logic [7:0] MLF_MODE_MASK = 8'h07;
	localparam logic [7:0] MLF_CONV_MASK = 8'hC3;
	// Converter input selections
	localparam logic [1:0] MLF_SEL_TEMP = 2'h0;
	localparam logic [1:0] MLF_SEL_SUPPLY = 2'h1;
	localparam logic [1:0] MLF_SEL_PD = 2'h2;
	localparam logic [1:0] MLF_SEL_BIAS = 2'h3;
	// Disable negate time
	localparam int MLF_CLK_MHZ = 50;
	localparam int MLF_NEGATE_NS = 1000;
	localparam int MLF_NEGATE_CYC = (MLF_NEGATE_NS * MLF_CLK_MHZ + 999) / 1000;
	localparam logic [7:0] MLF_NEGATE_CNT = 8'(MLF_NEGATE_CYC);
	// Fault supervisor states
	typedef enum logic [1:0] {
		MLF_ST_RUN = 2'b00,
		MLF_ST_FAULT = 2'b01,
		MLF_ST_DISABLED = 2'b10,
		MLF_ST_NEGATE = 2'b11
	} mlf_state_e;
	// Register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mlf_req_s;
	// Analog and digital monitor inputs
	typedef struct packed {
		logic bias_cmp;
		logic pd_cmp;
		logic [7:0] bias_meas;
		logic [7:0] pd_meas;
		logic [7:0] pd_setpoint;
		logic [7:0] bias_dac;
	} mlf_mon_s;
endpackage

// ===== design/mlf_sync.sv
// Two-flop synchroniser for a pin level.
// Assumes one clock domain on the inside.
`timescale 1ns/100ps
`default_nettype none
module mlf_sync (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Level in and out
	input wire logic din,
	output logic dout
);
	// First stage, read only by the second
	logic meta_reg;
	logic meta_next;
	logic sync_reg;
	logic sync_next;
	// Next values
	always_comb begin
		meta_next = din;
		sync_next = meta_reg;
	end
	// Stages
	always_ff @(posedge clock) begin
		if (rst) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end
	assign dout = sync_reg;
endmodule
`default_nettype wire

// ===== design/mlf_detect.sv
// Fault condition detector: compares monitors against thresholds.
// Assumes all monitor inputs are already synchronous to clock.
`timescale 1ns/100ps
`default_nettype none
module mlf_detect (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Configuration
	input wire logic [7:0] mode,
	input wire logic [7:0] bias_thr,
	input wire logic [7:0] pd_thr,
	// Monitors
	input wire mlf_pkg::mlf_mon_s mon,
	// Combined condition
	output logic fault_any
);
	// Previous bias DAC value for step check
	logic [7:0] dac_prev_reg;
	logic [7:0] dac_prev_next;
	logic bias_flt;
	logic pd_flt;
	logic over_flt;
	logic drop_flt;
	logic [8:0] pd_limit;
	// Detection terms
	always_comb begin
		dac_prev_next = mon.bias_dac;
		// RULE9: bias fault modes
		bias_flt = mode[mlf_pkg::MLF_DIG_BIAS_BIT] ? (mon.bias_meas > bias_thr) : mon.bias_cmp;
		// Analog trigger stays armed in digital mode; only its own bit gates it
		// RULE10: photodiode fault modes
		// RULE1: analog trigger gated
		pd_flt = (mode[mlf_pkg::MLF_DIG_PD_BIT] && (mon.pd_meas > pd_thr)) ||
			(mon.pd_cmp && mode[mlf_pkg::MLF_ANA_PD_FLT_BIT]);
		// RULE11: above 150 percent
		pd_limit = {1'b0, mon.pd_setpoint} + {2'b00, mon.pd_setpoint[7:1]};
		over_flt = {1'b0, mon.pd_meas} > pd_limit;
		// RULE12: drop over half step
		drop_flt = {1'b0, mon.bias_dac, 1'b0} < {2'b00, dac_prev_reg};
	end
	// Previous DAC sample
	always_ff @(posedge clock) begin
		if (rst) begin
			dac_prev_reg <= 8'h00;
		end else begin
			dac_prev_reg <= dac_prev_next;
		end
	end
	// RULE18: OR of all conditions
	assign fault_any = bias_flt | pd_flt | over_flt | drop_flt;
endmodule
`default_nettype wire

// ===== design/mlf_top.sv
// Monitor configuration, converter registers and laser-safety fault latch.
// Assumes the serial interface delivers single-cycle byte requests on clock.
// Summary of operation
// RULE1: Analog photodiode fault trigger enable bit
// RULE2: Photodiode monitor digital or analog select
// RULE3: Bias monitor digital or analog select
// RULE4: Bias threshold used in digital mode
// RULE5: Photodiode threshold used in digital mode
// RULE6: Converter and oscillator disable bits
// RULE7: Two-bit converter input selection
// RULE8: Ten-bit result read only, split
// RULE9: Bias fault from comparator or threshold
// RULE10: Photodiode fault from comparator or threshold
// RULE11: Fault above 150 percent setpoint
// RULE12: Fault on DAC drop over half
// RULE13: Fault zeroes bias, modulation; latches pin
// RULE14: Host toggles disable or enable long enough
// RULE15: Fault output low while disabled
// RULE16: Resume after negate time if clear
// RULE17: Persisting fault reasserts after disable release
// RULE18: Conditions ORed, latch held until recovery
`timescale 1ns/100ps
`default_nettype none
module mlf_top (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register port
	input wire mlf_pkg::mlf_req_s req,
	output logic [7:0] rdata,
	output logic rvalid,
	// Monitors
	input wire mlf_pkg::mlf_mon_s mon,
	// Converter side
	input wire logic [9:0] conv_result,
	input wire logic conv_done,
	output logic conv_off,
	output logic conv_osc_off,
	output logic [1:0] converter_input_select,
	// Safety controls
	input wire logic disable_pin,
	input wire logic internal_enable_bit,
	input wire logic fault_response_enable,
	// Drive gating and fault pin
	output logic bias_enable,
	output logic mod_enable,
	output logic fault_output
);
	// Register storage
	logic [7:0] mode_reg, mode_next;
	logic [7:0] bthr_reg, bthr_next;
	logic [7:0] pthr_reg, pthr_next;
	logic [7:0] cctl_reg, cctl_next;
	logic [9:0] res_reg, res_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	// Fault supervisor
	mlf_pkg::mlf_state_e st_reg, st_next;
	logic [7:0] cnt_reg, cnt_next;
	logic dis_sync;
	logic fault_any;
	logic off_req;
	// Checker helper: cycles spent in the negate wait
	logic [7:0] neg_cycles_reg, neg_cycles_next;

	// Disable pin comes from outside
	mlf_sync u_sync (
		.clock(clock),
		.rst(rst),
		.din(disable_pin),
		.dout(dis_sync)
	);

	// Condition detector
	mlf_detect u_det (
		.clock(clock),
		.rst(rst),
		.mode(mode_reg),
		.bias_thr(bthr_reg),
		.pd_thr(pthr_reg),
		.mon(mon),
		.fault_any(fault_any)
	);

	// Register writes and reads
	always_comb begin
		mode_next = mode_reg;
		bthr_next = bthr_reg;
		pthr_next = pthr_reg;
		cctl_next = cctl_reg;
		res_next = res_reg;
		rdata_next = rdata_reg;
		rvalid_next = req.rd;
		// Result captured while converter runs
		if (conv_done && !cctl_reg[mlf_pkg::MLF_CONV_OFF_BIT]) begin
			res_next = conv_result;
		end
		if (req.wr) begin
			case (req.addr)
				// RULE2: mode select bits stored
				// RULE3: bias select stored
				mlf_pkg::MLF_MON_MODE_ADDR: begin
					mode_next = req.wdata & mlf_pkg::MLF_MODE_MASK;
				end
				// RULE4: bias threshold
				mlf_pkg::MLF_BIAS_THR_ADDR: begin
					bthr_next = req.wdata;
				end
				// RULE5: photodiode threshold
				mlf_pkg::MLF_PD_THR_ADDR: begin
					pthr_next = req.wdata;
				end
				mlf_pkg::MLF_CONV_CTRL_ADDR: begin
					cctl_next = req.wdata & mlf_pkg::MLF_CONV_MASK;
				end
				// Result registers ignore writes
				default: begin
					cctl_next = cctl_reg;
				end
			endcase
		end
		if (req.rd) begin
			case (req.addr)
				mlf_pkg::MLF_MON_MODE_ADDR: rdata_next = mode_reg;
				mlf_pkg::MLF_BIAS_THR_ADDR: rdata_next = bthr_reg;
				mlf_pkg::MLF_PD_THR_ADDR: rdata_next = pthr_reg;
				mlf_pkg::MLF_CONV_CTRL_ADDR: rdata_next = cctl_reg;
				// RULE8: result split over two
				mlf_pkg::MLF_RES_HIGH_ADDR: rdata_next = res_reg[9:2];
				mlf_pkg::MLF_RES_LOW_ADDR: rdata_next = {6'h00, res_reg[1:0]};
				// Unmapped reads as zero
				default: rdata_next = 8'h00;
			endcase
		end
	end

	// Register file flops
	always_ff @(posedge clock) begin
		if (rst) begin
			mode_reg <= mlf_pkg::MLF_REG_RESET;
			bthr_reg <= mlf_pkg::MLF_REG_RESET;
			pthr_reg <= mlf_pkg::MLF_REG_RESET;
			cctl_reg <= mlf_pkg::MLF_REG_RESET;
			res_reg <= 10'h000;
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			bthr_reg <= bthr_next;
			pthr_reg <= pthr_next;
			cctl_reg <= cctl_next;
			res_reg <= res_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// RULE6: converter disable controls
	assign conv_off = cctl_reg[mlf_pkg::MLF_CONV_OFF_BIT];
	assign conv_osc_off = cctl_reg[mlf_pkg::MLF_OSC_OFF_BIT];
	// RULE7: input selection field
	assign converter_input_select = cctl_reg[1:0];
	assign rdata = rdata_reg;
	assign rvalid = rvalid_reg;

	// Recovery request: pin high or enable low
	assign off_req = dis_sync | !internal_enable_bit;

	// Fault supervisor next state
	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		case (st_reg)
			mlf_pkg::MLF_ST_RUN: begin
				// RULE13: latch on enabled fault
				if (off_req) begin
					st_next = mlf_pkg::MLF_ST_DISABLED;
				end else if (fault_any && fault_response_enable) begin
					st_next = mlf_pkg::MLF_ST_FAULT;
				end
			end
			mlf_pkg::MLF_ST_FAULT: begin
				// RULE18: held until recovery
				// RULE14: host toggles to clear
				if (off_req) begin
					st_next = mlf_pkg::MLF_ST_DISABLED;
				end
			end
			mlf_pkg::MLF_ST_DISABLED: begin
				cnt_next = mlf_pkg::MLF_NEGATE_CNT;
				// RULE17: persisting fault relatches
				if (!off_req && fault_any && fault_response_enable) begin
					st_next = mlf_pkg::MLF_ST_FAULT;
				end else if (!off_req) begin
					st_next = mlf_pkg::MLF_ST_NEGATE;
				end
			end
			mlf_pkg::MLF_ST_NEGATE: begin
				// RULE16: wait negate time
				if (off_req) begin
					st_next = mlf_pkg::MLF_ST_DISABLED;
				end else if (fault_any && fault_response_enable) begin
					st_next = mlf_pkg::MLF_ST_FAULT;
				end else if (cnt_reg == 8'h01) begin
					st_next = mlf_pkg::MLF_ST_RUN;
				end else begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
			default: begin
				st_next = mlf_pkg::MLF_ST_FAULT;
			end
		endcase
	end

	// Supervisor flops
	always_ff @(posedge clock) begin
		if (rst) begin
			st_reg <= mlf_pkg::MLF_ST_DISABLED;
			cnt_reg <= 8'h00;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
		end
	end

	// RULE13: drive gated off except running
	assign bias_enable = (st_reg == mlf_pkg::MLF_ST_RUN);
	assign mod_enable = (st_reg == mlf_pkg::MLF_ST_RUN);
	// RULE15: pin low while disabled
	assign fault_output = (st_reg == mlf_pkg::MLF_ST_FAULT);

	// RULE13: latch on the next cycle
	AST_FAULT_LATCH: assert property (@(posedge clock) disable iff (rst) // RULE13
		(st_reg == mlf_pkg::MLF_ST_RUN && !off_req && fault_any && fault_response_enable)
		|=> fault_output && !bias_enable && !mod_enable)
		else $error("fault not latched");
	// RULE15: disabled keeps pin low
	AST_DIS_LOW: assert property (@(posedge clock) disable iff (rst) // RULE15
		off_req |=> !fault_output)
		else $error("fault pin high while disabled");
	// RULE18: latch holds without recovery
	AST_HOLD: assert property (@(posedge clock) disable iff (rst) // RULE18
		fault_output && !off_req |=> fault_output)
		else $error("fault latch dropped");
	// RULE16: negate wait length
	AST_NEGATE: assert property (@(posedge clock) disable iff (rst) // RULE16
		$rose(st_reg == mlf_pkg::MLF_ST_NEGATE) |-> !bias_enable [*8])
		else $error("resumed early");
	// RULE17: relatch on persisting fault
	AST_RELATCH: assert property (@(posedge clock) disable iff (rst) // RULE17
		st_reg == mlf_pkg::MLF_ST_DISABLED && !off_req && fault_any && fault_response_enable
		|=> fault_output)
		else $error("persisting fault not relatched");
	// RULE8: low result upper bits zero
	AST_RES_LOW: assert property (@(posedge clock) disable iff (rst) // RULE8
		req.rd && req.addr == mlf_pkg::MLF_RES_LOW_ADDR |=> rvalid && rdata[7:2] == 6'h00)
		else $error("result low reserved bits set");
	// RULE8: result not writable
	AST_RES_RO: assert property (@(posedge clock) disable iff (rst) // RULE8
		!conv_done |=> res_reg == $past(res_reg))
		else $error("result changed without conversion");
	// RULE7: select follows register
	AST_SEL: assert property (@(posedge clock) disable iff (rst) // RULE7
		req.wr && req.addr == mlf_pkg::MLF_CONV_CTRL_ADDR
		|=> converter_input_select == $past(req.wdata[1:0]) && conv_off == $past(req.wdata[7]))
		else $error("converter control not applied");
	// RULE1: analog pd ignored when off
	AST_PD_GATE: assert property (@(posedge clock) disable iff (rst) // RULE1
		st_reg == mlf_pkg::MLF_ST_RUN && !off_req && fault_response_enable
		&& mode_reg == 8'h00 && !mon.bias_cmp && mon.pd_cmp
		&& ({1'b0, mon.pd_meas} <= {1'b0, mon.pd_setpoint} + {2'b00, mon.pd_setpoint[7:1]})
		&& ({1'b0, mon.bias_dac, 1'b0} >= {2'b00, $past(mon.bias_dac)})
		|=> !fault_output)
		else $error("gated analog pd fault latched");

	// Checker helper: count cycles in the negate wait
	always_comb begin
		neg_cycles_next = 8'h00;
		if (st_reg == mlf_pkg::MLF_ST_NEGATE) begin
			neg_cycles_next = neg_cycles_reg + 8'h01;
		end
	end
	// Checker helper flop; a counter keeps the long window cheap to check
	always_ff @(posedge clock) begin
		if (rst) begin
			neg_cycles_reg <= 8'h00;
		end else begin
			neg_cycles_reg <= neg_cycles_next;
		end
	end
	// RULE16: full negate time before resuming
	AST_NEGATE_LEN: assert property (@(posedge clock) disable iff (rst) // RULE16
		st_reg == mlf_pkg::MLF_ST_NEGATE && st_next == mlf_pkg::MLF_ST_RUN
		|-> neg_cycles_reg == mlf_pkg::MLF_NEGATE_CNT - 8'h01)
		else $error("negate wait length wrong");
	// RULE16: drive off while recovery held
	AST_OFF_DRIVE: assert property (@(posedge clock) disable iff (rst) // RULE16
		off_req |=> !bias_enable && !mod_enable)
		else $error("drive on while disabled");
	// RULE4: digital bias threshold trips
	AST_DIG_BIAS: assert property (@(posedge clock) disable iff (rst) // RULE4
		st_reg == mlf_pkg::MLF_ST_RUN && !off_req && fault_response_enable
		&& mode_reg[mlf_pkg::MLF_DIG_BIAS_BIT] && (mon.bias_meas > bthr_reg)
		|=> fault_output)
		else $error("digital bias fault missed");
	// RULE5: digital photodiode threshold trips
	AST_DIG_PD: assert property (@(posedge clock) disable iff (rst) // RULE5
		st_reg == mlf_pkg::MLF_ST_RUN && !off_req && fault_response_enable
		&& mode_reg[mlf_pkg::MLF_DIG_PD_BIT] && (mon.pd_meas > pthr_reg)
		|=> fault_output)
		else $error("digital photodiode fault missed");
	// RULE13: no latch with response off
	AST_NO_RESP: assert property (@(posedge clock) disable iff (rst) // RULE13
		st_reg == mlf_pkg::MLF_ST_RUN && !fault_response_enable |=> !fault_output)
		else $error("fault latched with response off");
	// RULE8: high result byte read back
	AST_RES_HIGH: assert property (@(posedge clock) disable iff (rst) // RULE8
		req.rd && req.addr == mlf_pkg::MLF_RES_HIGH_ADDR |=> rvalid && rdata == $past(res_reg[9:2]))
		else $error("result high byte wrong");
endmodule
`default_nettype wire

// ===== tb/mlf_host.sv
// Host controller model: register port master and safety pin driver.
// Assumes the bench calls its tasks from the falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module mlf_host (
	// Clock
	input wire logic clock,
	// Register port
	output var mlf_pkg::mlf_req_s req,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	// Safety pins
	output logic disable_pin,
	output logic internal_enable_bit
);
	// Idle port, pin low, enable high
	initial begin
		req = '0;
		disable_pin = 1'b0;
		internal_enable_bit = 1'b1;
	end
	// Byte write; idle bus shows inverted values so stale data cannot pass
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clock);
		req.addr = a;
		req.wdata = v;
		req.wr = 1'b1;
		@(negedge clock);
		req.wr = 1'b0;
		req.addr = ~a;
		req.wdata = ~v;
	endtask
	// Byte read; unknown returned if no answer pulse
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge clock);
		req.addr = a;
		req.rd = 1'b1;
		@(negedge clock);
		req.rd = 1'b0;
		req.addr = ~a;
		v = (rvalid === 1'b1) ? rdata : 8'hXX;
	endtask
	task toggle(input logic use_pin, input int hold);
		@(negedge clock);
		if (use_pin) disable_pin = 1'b1;
		else internal_enable_bit = 1'b0;
		repeat (hold) @(negedge clock);
		disable_pin = 1'b0;
		internal_enable_bit = 1'b1;
	endtask
endmodule
`default_nettype wire

// ===== tb/test_mlf_top.sv
// Self-checking bench for the monitor, converter and fault latch block.
// Assumes the host model owns the register port and the safety pins.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
module test_mlf_top;
	// Clock, reset, counters
	logic clock = 1'b0;
	logic rst = 1'b1;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [7:0] d;
	// Design connections
	mlf_pkg::mlf_req_s req;
	mlf_pkg::mlf_mon_s mon;
	logic [7:0] rdata;
	logic [9:0] conv_result;
	logic [1:0] converter_input_select;
	logic rvalid, conv_done, conv_off, conv_osc_off, disable_pin, internal_enable_bit;
	logic fault_response_enable, bias_enable, mod_enable, fault_output;
	// 50 MHz clock
	always #10 clock = ~clock;
	// Hang guard, far above the expected run
	always @(posedge clock) begin
		cycles++;
		if (cycles == 6000) begin
			fails++;
			final_report();
		end
	end
	mlf_top i_mlf_top (.clock(clock), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
		.mon(mon), .conv_result(conv_result), .conv_done(conv_done), .conv_off(conv_off),
		.conv_osc_off(conv_osc_off), .converter_input_select(converter_input_select),
		.disable_pin(disable_pin), .internal_enable_bit(internal_enable_bit),
		.fault_response_enable(fault_response_enable), .bias_enable(bias_enable),
		.mod_enable(mod_enable), .fault_output(fault_output));
	mlf_host i_mlf_host (.clock(clock), .req(req), .rdata(rdata), .rvalid(rvalid),
		.disable_pin(disable_pin), .internal_enable_bit(internal_enable_bit));
	// Quiet monitors; setpoint high so the ratio check stays clear
	task idle;
		mon = '0;
		mon.pd_setpoint = 8'hA0;
	endtask
	// Read and compare one register
	task rchk(input logic [7:0] a, input logic [7:0] e);
		i_mlf_host.rd(a, d);
		`CHK("rdata", e, d)
	endtask
	// Fault pin and drive gating after settling
	task chk_fault(input logic e);
		repeat (3) @(negedge clock);
		`CHK("fault_output", e, fault_output)
		`CHK("bias_enable", ~e, bias_enable)
		`CHK("mod_enable", ~e, mod_enable)
	endtask
	// Clear causes, toggle enable, wait out the negate time
	task recover;
		idle();
		fork
			i_mlf_host.toggle(1'b0, 4);
			begin
				repeat (3) @(negedge clock);
				`CHK("fault_off", 1'b0, fault_output)
			end
		join
		repeat (45) @(negedge clock);
		`CHK("negate_wait", 1'b0, bias_enable)
		repeat (10) @(negedge clock);
		chk_fault(1'b0);
	endtask
	// One converter completion pulse
	task pulse(input logic [9:0] v);
		@(negedge clock);
		conv_result = v;
		conv_done = 1'b1;
		@(negedge clock);
		conv_done = 1'b0;
	endtask
	// Reset values, masks, read-only and unmapped places
	task t_regs;
		for (int a = 10; a < 16; a++) rchk(8'(a), 8'h00);
		i_mlf_host.wr(8'h0A, 8'hFF);
		rchk(8'h0A, 8'h07);
		i_mlf_host.wr(8'h0D, 8'hFF);
		rchk(8'h0D, 8'hC3);
		`CHK("conv_off", 1'b1, conv_off)
		`CHK("osc_off", 1'b1, conv_osc_off)
		for (int s = 0; s < 4; s++) begin
			i_mlf_host.wr(8'h0D, 8'(s));
			`CHK("input_select", 2'(s), converter_input_select)
		end
		`CHK("conv_on", 1'b0, conv_off)
		`CHK("osc_on", 1'b0, conv_osc_off)
		i_mlf_host.wr(8'h0E, 8'h55);
		rchk(8'h0E, 8'h00);
		rchk(8'h20, 8'h00);
		i_mlf_host.wr(8'h0A, 8'h00);
	endtask
	// Result split, and no capture while the converter is off
	task t_result;
		pulse(10'h2A5);
		rchk(8'h0E, 8'hA9);
		rchk(8'h0F, 8'h01);
		i_mlf_host.wr(8'h0D, 8'h80);
		pulse(10'h155);
		rchk(8'h0E, 8'hA9);
		i_mlf_host.wr(8'h0D, 8'h00);
	endtask
	// Bias threshold only in digital mode, comparator in analog mode
	task t_bias;
		mon.bias_meas = 8'h41;
		i_mlf_host.wr(8'h0B, 8'h40);
		chk_fault(1'b0);
		i_mlf_host.wr(8'h0A, 8'h01);
		chk_fault(1'b1);
		recover();
		mon.bias_meas = 8'h40;
		chk_fault(1'b0);
		i_mlf_host.wr(8'h0A, 8'h00);
		mon.bias_cmp = 1'b1;
		chk_fault(1'b1);
		recover();
	endtask
	// Photodiode trigger gating and digital threshold
	task t_pd;
		mon.pd_cmp = 1'b1;
		chk_fault(1'b0);
		i_mlf_host.wr(8'h0A, 8'h04);
		chk_fault(1'b1);
		recover();
		i_mlf_host.wr(8'h0A, 8'h00);
		i_mlf_host.wr(8'h0C, 8'h30);
		mon.pd_meas = 8'h31;
		chk_fault(1'b0);
		i_mlf_host.wr(8'h0A, 8'h02);
		chk_fault(1'b1);
		recover();
		mon.pd_cmp = 1'b1;
		chk_fault(1'b0);
		i_mlf_host.wr(8'h0A, 8'h06);
		chk_fault(1'b1);
		recover();
		i_mlf_host.wr(8'h0A, 8'h00);
	endtask
	// Ratio to setpoint and DAC collapse, both at the boundary
	task t_ratio;
		mon.pd_setpoint = 8'h40;
		mon.pd_meas = 8'h60;
		chk_fault(1'b0);
		mon.pd_meas = 8'h61;
		chk_fault(1'b1);
		recover();
		mon.bias_dac = 8'h80;
		repeat (2) @(negedge clock);
		mon.bias_dac = 8'h40;
		chk_fault(1'b0);
		mon.bias_dac = 8'h80;
		repeat (2) @(negedge clock);
		mon.bias_dac = 8'h3F;
		chk_fault(1'b1);
		recover();
	endtask
	// Response enable, latch hold, persisting fault through pin toggle
	task t_latch;
		fault_response_enable = 1'b0;
		mon.bias_cmp = 1'b1;
		chk_fault(1'b0);
		fault_response_enable = 1'b1;
		chk_fault(1'b1);
		mon.bias_cmp = 1'b0;
		chk_fault(1'b1);
		mon.bias_cmp = 1'b1;
		fork
			i_mlf_host.toggle(1'b1, 6);
			begin
				repeat (5) @(negedge clock);
				`CHK("pin_off", 1'b0, fault_output)
			end
		join
		repeat (2) @(negedge clock);
		chk_fault(1'b1);
		recover();
	endtask
	// Counts and verdict
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		idle();
		conv_result = 10'h000;
		conv_done = 1'b0;
		fault_response_enable = 1'b1;
		repeat (2) @(negedge clock);
		rst = 1'b0;
		repeat (60) @(negedge clock);
		chk_fault(1'b0);
		t_regs();
		t_result();
		t_bias();
		t_pd();
		t_ratio();
		t_latch();
		final_report();
	end
endmodule
`default_nettype wire
